//--- shared/tw_pkg.sv
package tw_pkg;

    // ==========================================
    // Key register and protected bit addresses
    localparam logic [7:0] KEY_ADDR = 8'hC7;
    localparam logic [7:0] KEY_FIRST = 8'hAA;
    localparam logic [7:0] KEY_SECOND = 8'h55;
    localparam logic [7:0] WDT_CTRL_ADDR = 8'hD8;
    localparam logic [7:0] WDT_EN_BIT_ADDR = 8'hD9;
    localparam int WDT_EN_POS = 1;

    // ==========================================
    // Timing
    localparam int CLK_PER_MC = 4;
    localparam logic [1:0] MC_DIV_LAST = 2'(CLK_PER_MC - 1);
    localparam logic [1:0] WINDOW_MC = 2'h3;
    localparam logic WDT_EN_RST = 1'b1;
    localparam int WDT_MC_DEFAULT = 8192;

    // ==========================================
    // Core special register write
    typedef struct packed {
        logic byte_wr;
        logic bit_wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic bit_val;
    } sfr_wr_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_KEY1 = 3'h2,
        ST_OPEN = 3'h4
    } key_state_e;

endpackage

//--- design/timed_write_protect.sv
`timescale 1ns/1ps

// How it works
// [RULE1] AAh then 55h within three cycles arms
// [RULE2] Protected write accepted within three cycles only
// [RULE3] Second protected write after window is rejected
// [RULE4] Clearing watchdog enable bit without window ignored
// [RULE5] Watchdog keeps counting, timeout resets device
// [RULE6] No bypass; key sequence before every change
// [RULE7] Closed window ignores all protected writes
// [RULE8] Any failed step returns to idle
// [RULE9] Wrong key discards progress; AAh restarts
module timed_write_protect
    import tw_pkg::*;
#(
    parameter int WDT_MC = WDT_MC_DEFAULT
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Core write port
    input wire logic WR_BYTE,
    input wire logic WR_BIT,
    input wire logic [7:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_BIT_VAL,
    // Watchdog service
    input wire logic WDT_KICK,
    // Status
    output logic WINDOW_OPEN,
    output logic WDT_RESET_ENABLE,
    output logic WDT_RESET
);

    // ==========================================
    // Machine cycle enable
    logic [1:0] div_q;
    logic [1:0] div_d;
    wire mc_tick = (div_q == MC_DIV_LAST);
    assign div_d = mc_tick ? 2'h0 : 2'(div_q + 2'h1);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // ==========================================
    // Write decode
    sfr_wr_s wr;
    assign wr = '{
        byte_wr: WR_BYTE,
        bit_wr: WR_BIT,
        addr: WR_ADDR,
        data: WR_DATA,
        bit_val: WR_BIT_VAL
    };

    // Key register writes
    wire key_wr = wr.byte_wr && (wr.addr == KEY_ADDR);
    wire key_is_first = key_wr && (wr.data == KEY_FIRST);
    wire key_is_second = key_wr && (wr.data == KEY_SECOND);
    // Any value but AAh ends a sequence in progress, except 55h right after AAh, which arms
    wire key_not_first = key_wr && !key_is_first;

    // Protected targets: whole control byte or its enable bit
    wire prot_byte_wr = wr.byte_wr && (wr.addr == WDT_CTRL_ADDR);
    wire prot_bit_wr = wr.bit_wr && (wr.addr == WDT_EN_BIT_ADDR);
    wire prot_wr = prot_byte_wr || prot_bit_wr;
    wire prot_val = prot_bit_wr ? wr.bit_val : wr.data[WDT_EN_POS];

    // ==========================================
    // Window timer, counted in machine cycles
    logic [1:0] mc_left_q;
    logic [1:0] mc_left_d;
    wire timer_out = (mc_left_q == 2'h0);
    wire [1:0] mc_left_dec = (mc_tick && !timer_out) ? 2'(mc_left_q - 2'h1) : mc_left_q;

    // ==========================================
    // Key sequence state
    key_state_e state_q;
    key_state_e state_d;
    wire in_key1 = (state_q == ST_KEY1);
    wire in_open = (state_q == ST_OPEN);
    wire in_window = in_open && !timer_out;
    wire prot_accept = prot_wr && in_window; // [RULE2] [RULE6]

    // Decisions per state; a fresh AAh outranks all of them
    wire key1_lapse = in_key1 && timer_out; // [RULE1] [RULE8]
    wire key1_arm = in_key1 && !timer_out && key_is_second; // [RULE1]
    wire key1_abort = in_key1 && !timer_out && key_not_first && !key_is_second; // [RULE9]
    // One change per window: an accepted write closes it
    wire open_close = in_open && (timer_out || prot_accept); // [RULE3] [RULE7]
    wire open_abort = in_open && key_not_first; // [RULE9]

    // A lapse and a wrong key both end at idle; software restarts from AAh
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_IDLE;
            end
            ST_KEY1: begin
                if (key1_lapse || key1_abort) begin
                    state_d = ST_IDLE; // [RULE8]
                end else if (key1_arm) begin
                    state_d = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (open_close || open_abort) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (key_is_first) begin
            state_d = ST_KEY1; // [RULE9]
        end
    end

    // Both stages restart the same three-cycle budget
    always_comb begin
        mc_left_d = mc_left_dec;
        if (key_is_first || key1_arm) begin
            mc_left_d = WINDOW_MC;
        end
    end

    // ==========================================
    // Protected watchdog reset enable
    logic wdt_en_q;
    wire wdt_en_d = prot_accept ? prot_val : wdt_en_q; // [RULE4] [RULE7]

    // ==========================================
    // Watchdog counter, machine-cycle based
    // Counting cannot be stopped by software, so runaway code still times out
    logic [31:0] wdt_cnt_q;
    logic [31:0] wdt_cnt_d;
    wire wdt_expire = mc_tick && (wdt_cnt_q == 32'(WDT_MC - 1));
    wire wdt_reset_d = wdt_expire && wdt_en_q; // [RULE5]

    // Kick and expiry both restart the count
    always_comb begin
        wdt_cnt_d = wdt_cnt_q;
        if (WDT_KICK || wdt_expire) begin
            wdt_cnt_d = 32'h0; // [RULE5]
        end else if (mc_tick) begin
            wdt_cnt_d = wdt_cnt_q + 32'h1;
        end
    end

    // ==========================================
    // Registered output next values
    wire window_open_d = (state_d == ST_OPEN) && (mc_left_d != 2'h0);

    // ==========================================
    // State registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mc_left_q <= 2'h0;
        end else begin
            mc_left_q <= mc_left_d;
        end
    end

    // ==========================================
    // Watchdog registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdt_en_q <= WDT_EN_RST;
        end else begin
            wdt_en_q <= wdt_en_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wdt_cnt_q <= 32'h0;
        end else begin
            wdt_cnt_q <= wdt_cnt_d;
        end
    end

    // ==========================================
    // Output registers
    // Pulse only while the enable stands
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WDT_RESET <= 1'b0;
        end else begin
            WDT_RESET <= wdt_reset_d; // [RULE5]
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WINDOW_OPEN <= 1'b0;
        end else begin
            WINDOW_OPEN <= window_open_d;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WDT_RESET_ENABLE <= WDT_EN_RST;
        end else begin
            WDT_RESET_ENABLE <= wdt_en_d;
        end
    end

endmodule

//--- verification/tw_chk.sv
`timescale 1ns/1ps
module tw_chk
    import tw_pkg::*;
#(parameter int WDT_MC = 8) (
    // Watched ports
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic WR_BYTE,
    input wire logic WR_BIT,
    input wire logic [7:0] WR_ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WINDOW_OPEN,
    input wire logic WDT_RESET_ENABLE,
    input wire logic WDT_RESET
);
    // =========
    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire key_b = WR_BYTE && WR_ADDR == KEY_ADDR;
    wire pb = WR_BIT && WR_ADDR == WDT_EN_BIT_ADDR;
    arm_key_a: assert property ($rose(WINDOW_OPEN) |-> $past(key_b && WR_DATA == KEY_SECOND)) else $error("no key");
    win_len_a: assert property ($rose(WINDOW_OPEN) |-> ##[1:12] !WINDOW_OPEN) else $error("long window");
    chg_open_a: assert property ($changed(WDT_RESET_ENABLE) |-> $past(WINDOW_OPEN)) else $error("locked change");
    one_chg_a: assert property ($changed(WDT_RESET_ENABLE) |-> !WINDOW_OPEN) else $error("window stayed");
    bit_close_a: assert property (WINDOW_OPEN && pb |=> !WINDOW_OPEN) else $error("still open");
    abort_a: assert property (key_b && WR_DATA != KEY_SECOND |=> !WINDOW_OPEN) else $error("abort lost");
    wdt_en_a: assert property (WDT_RESET |-> $past(WDT_RESET_ENABLE)) else $error("reset while off");
    wdt_pulse_a: assert property (WDT_RESET |=> !WDT_RESET) else $error("long reset");
    cover property ($rose(WINDOW_OPEN));
    cover property ($fell(WDT_RESET_ENABLE));
    cover property (WDT_RESET);
endmodule
bind timed_write_protect tw_chk #(.WDT_MC(WDT_MC)) chk_u (.CLK(CLK), .RST_N(RST_N), .WR_BYTE(WR_BYTE),
    .WR_BIT(WR_BIT), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WINDOW_OPEN(WINDOW_OPEN),
    .WDT_RESET_ENABLE(WDT_RESET_ENABLE), .WDT_RESET(WDT_RESET));

//--- verification/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
    import tw_pkg::*;
(
    // Core side
    input wire logic clk,
    output sfr_wr_s w
);
    // =========
    // One strobe cycle per write; released lines show inverse data
    initial w = '0;
    task automatic wr(input logic byt, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        w = '{byt, !byt, a, d, d[0]};
        @(posedge clk) #1;
        w = '{1'h0, 1'h0, ~a, ~d, ~d[0]};
    endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import tw_pkg::*;
;
    logic clk = 0, rst_n = 0, kick = 1, win, en, wdr;
    sfr_wr_s w;
    int failures = 0, total_checks = 0;
    always #25 clk = ~clk;
    cpu_model cpu_u (.clk(clk), .w(w));
    timed_write_protect #(.WDT_MC(8)) dut_u (.CLK(clk), .RST_N(rst_n), .WR_BYTE(w.byte_wr), .WR_BIT(w.bit_wr),
        .WR_ADDR(w.addr), .WR_DATA(w.data), .WR_BIT_VAL(w.bit_val), .WDT_KICK(kick),
        .WINDOW_OPEN(win), .WDT_RESET_ENABLE(en), .WDT_RESET(wdr));
    // =========
    // Helpers
    task automatic chk(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic kw(input logic [7:0] d);
        cpu_u.wr(1'h1, KEY_ADDR, d);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // =========
    // Scenarios
    task automatic t_wdt();
        kick = 0;
        for (int i = 0; i < 80 && wdr !== 1'h1; i++) @(posedge clk) #1;
        chk("wdt_reset", 1'h1, wdr);
        kick = 1;
    endtask
    task automatic t_stray();
        cpu_u.wr(1'h0, WDT_EN_BIT_ADDR, 8'h00);
        chk("stray_clr", 1'h1, en);
        cpu_u.wr(1'h1, WDT_CTRL_ADDR, 8'h00);
        chk("stray_byte", 1'h1, en);
    endtask
    task automatic t_wrong();
        kw(KEY_FIRST); kw(8'h33); kw(KEY_SECOND);
        chk("bad_key", 1'h0, win);
        kw(KEY_FIRST); kw(KEY_FIRST); kw(KEY_SECOND);
        chk("restart", 1'h1, win);
        cpu_u.wr(1'h0, WDT_EN_BIT_ADDR, 8'h01);
        chk("closed", 1'h0, win);
    endtask
    task automatic t_late();
        kw(KEY_FIRST); kw(KEY_SECOND);
        repeat (14) @(posedge clk);
        cpu_u.wr(1'h0, WDT_EN_BIT_ADDR, 8'h00);
        chk("late_clr", 1'h1, en);
        kw(KEY_FIRST);
        repeat (14) @(posedge clk);
        kw(KEY_SECOND);
        chk("late_key", 1'h0, win);
    endtask
    task automatic t_valid();
        kw(KEY_FIRST); kw(KEY_SECOND);
        cpu_u.wr(1'h0, WDT_EN_BIT_ADDR, 8'h00);
        chk("clr_ok", 1'h0, en);
        cpu_u.wr(1'h0, WDT_EN_BIT_ADDR, 8'h01);
        chk("second", 1'h0, en);
        kw(KEY_FIRST); kw(KEY_SECOND);
        cpu_u.wr(1'h1, WDT_CTRL_ADDR, 8'h02);
        chk("rekey", 1'h1, en);
    endtask
    // Whole run is about a hundred cycles; the limit leaves wide margin
    initial begin
        #150000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        t_wdt();
        t_stray();
        t_wrong();
        t_late();
        t_valid();
        tally_and_finish();
    end
endmodule
